/* spr_pkg.sv */
// Purpose: Shared constants for the serial register port (both ends).
// Assumes: Host clock 50 MHz; link frames in clock mode 00.
// Notes:   Counts of host cycles are derived from times in ns.
package spr_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 20;
	localparam int SCLK_MIN_PERIOD_NS = 250;
	localparam int CS_SETUP_NS        = 125;
	localparam int CS_HOLD_NS         = 240;
	localparam int CS_IDLE_NS         = 600;
	localparam int TMR_W              = 5;

	function automatic int spr_ns2cyc(input int ns);
		return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

	localparam int SCLK_HALF_CYC = spr_ns2cyc(SCLK_MIN_PERIOD_NS / 2);
	localparam int CS_SETUP_CYC  = spr_ns2cyc(CS_SETUP_NS);
	localparam int CS_HOLD_CYC   = spr_ns2cyc(CS_HOLD_NS);
	localparam int CS_IDLE_CYC   = spr_ns2cyc(CS_IDLE_NS);

	// ----------------------------------------------------------------
	// Frame layout (count of rising edges seen in the frame)
	// ----------------------------------------------------------------
	localparam logic [4:0] CNT_RW       = 5'h00;
	localparam logic [4:0] CNT_ADDR_END = 5'h07;
	localparam logic [4:0] CNT_DATA     = 5'h10;
	localparam logic [4:0] CNT_LAST     = 5'h17;
	localparam logic [4:0] CNT_WRAP     = 5'h18;
	localparam logic [4:0] CNT_WRAP_TO  = 5'h11;
	localparam logic [7:0] DUMMY_BYTE   = 8'h00;

	// ----------------------------------------------------------------
	// Wire-mode bit in sensor_config_one
	// ----------------------------------------------------------------
	localparam logic [6:0] CFG_REG_ADDR   = 7'h15;
	localparam int         CFG_WIRE3_BIT  = 0;
	localparam logic       WIRE3_AT_RESET = 1'b0;
endpackage

/* spr_if.sv */
// Purpose: Serial link between host and device ends.
// Assumes: Undriven data lines float high through pull-ups.
// Notes:   Resolves the shared data pin from both enables.
`timescale 1ns/1ns
interface spr_if;
	logic sclk;
	logic cs_n;
	logic host_sdio_o;
	logic host_sdio_oe;
	logic dev_sdio_o;
	logic dev_sdio_oe;
	logic dev_miso_o;
	logic dev_miso_oe;
	logic sdio;
	logic miso;

	// ----------------------------------------------------------------
	// Pin resolution
	// ----------------------------------------------------------------
	assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);
	assign miso = dev_miso_oe ? dev_miso_o : 1'b1;

	modport dev  (input sclk, cs_n, sdio, output dev_sdio_o, dev_sdio_oe, dev_miso_o, dev_miso_oe);
	modport host (output sclk, cs_n, host_sdio_o, host_sdio_oe, input sdio, miso);
endinterface

/* spr_sync.sv */
// Purpose: Two-stage synchroniser for levels and toggles.
// Assumes: Input changes no faster than the destination clock.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ns
module spr_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			meta <= '0;
			o_q  <= '0;
		end else begin
			meta <= i_d;
			o_q  <= meta;
		end
	end
endmodule

/* spr_device.sv */
// Purpose: Secondary end of the serial register port.
// Assumes: Register map lives on i_mclk; i_rd_data follows o_rd_addr.
// Notes:   Link logic runs on the serial clock; toggles cross domains.
// Contract
// RQ1 - Device only answers, never starts transfers
// RQ2 - Clock mode 00, clock idles low
// RQ3 - Sample on rise, change on fall
// RQ4 - Host holds select low whole transfer
// RQ5 - 24 clocks per byte, 8 more each
// RQ6 - First bit: 1 read, 0 write
// RQ7 - Bits two to eight: address, MSB first
// RQ8 - 4-wire after reset; write 1 for 3-wire
// RQ9 - Write ignores byte two, data pulses 17-24
// RQ10 - 4-wire read shifts data out pulses 17-24
// RQ11 - Multi-byte read increments address per byte
// RQ12 - Select rising edge ends the transaction
// RQ13 - 3-wire uses input pin bidirectionally
// RQ14 - 3-wire read drives at fall 16
// RQ15 - 3-wire keeps serial output disabled
// RQ16 - Host clock at most 4 MHz
// RQ17 - 4-wire output drives only during read data
// RQ18 - Multi-byte write increments address per byte
`timescale 1ns/1ns
module spr_device
	import spr_pkg::*;
(
	spr_if.dev               link,
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	output logic             o_wr_valid,
	output logic       [6:0] o_wr_addr,
	output logic       [7:0] o_wr_data,
	output logic       [6:0] o_rd_addr,
	input  wire logic  [7:0] i_rd_data
);
	// ----------------------------------------------------------------
	// Link-side state
	// ----------------------------------------------------------------
	logic [4:0] cnt;
	logic       rw;
	logic [6:0] addr;
	logic [6:0] rx;
	logic       wire3;
	logic       wr_tgl;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic       rq_tgl;
	logic [6:0] rq_addr;
	logic       ack_s;
	logic       ack_seen;
	logic [7:0] rd_buf;
	logic [7:0] tx;
	logic       drv;
	logic       frame_rst;
	logic [7:0] byte_in;

	// ----------------------------------------------------------------
	// Host-clock side state
	// ----------------------------------------------------------------
	logic       ack_tgl;
	logic [7:0] rd_hold;
	logic       rd_pend;
	logic [1:0] req_s;
	logic [1:0] req_seen;

	assign frame_rst = i_reset | link.cs_n; // RQ12
	assign byte_in   = {rx, link.sdio};

	// ----------------------------------------------------------------
	// Frame counter and header capture
	// ----------------------------------------------------------------
	// Bit count wraps into a repeating 8-bit data phase.
	always_ff @(posedge link.sclk or posedge frame_rst) begin
		if (frame_rst) begin
			cnt <= CNT_RW;
		end else if (cnt == CNT_WRAP) begin
			cnt <= CNT_WRAP_TO; // RQ5
		end else begin
			cnt <= cnt + 5'h01; // RQ5
		end
	end

	always_ff @(posedge link.sclk or posedge frame_rst) begin
		if (frame_rst) begin
			rw   <= 1'b0;
			addr <= '0;
			rx   <= '0;
		end else begin
			if (cnt == CNT_RW)
				rw <= link.sdio; // RQ6
			if (cnt > CNT_RW && cnt <= CNT_ADDR_END)
				addr <= {addr[5:0], link.sdio}; // RQ7
			else if (cnt == CNT_LAST)
				addr <= addr + 7'h01; // RQ11 RQ18
			if (cnt >= CNT_DATA)
				rx <= byte_in[6:0]; // RQ9
		end
	end

	// ----------------------------------------------------------------
	// Write commit and wire-mode bit
	// ----------------------------------------------------------------
	always_ff @(posedge link.sclk or posedge i_reset) begin
		if (i_reset) begin
			wr_tgl  <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wire3   <= WIRE3_AT_RESET; // RQ8
		end else if (!rw && cnt == CNT_LAST) begin
			wr_tgl  <= ~wr_tgl; // RQ9 RQ18
			wr_addr <= addr;
			wr_data <= byte_in;
			if (addr == CFG_REG_ADDR)
				wire3 <= byte_in[CFG_WIRE3_BIT]; // RQ8
		end
	end

	// ----------------------------------------------------------------
	// Read prefetch: first at address end, then next address per byte
	// ----------------------------------------------------------------
	always_ff @(posedge link.sclk or posedge i_reset) begin
		if (i_reset) begin
			rq_tgl  <= 1'b0;
			rq_addr <= '0;
		end else if (cnt == CNT_ADDR_END) begin
			rq_tgl  <= ~rq_tgl;
			rq_addr <= {addr[5:0], link.sdio};
		end else if (rw && (cnt == CNT_DATA || cnt == CNT_WRAP)) begin
			rq_tgl  <= ~rq_tgl; // RQ11
			rq_addr <= addr + 7'h01;
		end
	end

	spr_sync #(.W(1)) u_ack_sync (
		.i_clk   (link.sclk),
		.i_reset (i_reset),
		.i_d     (ack_tgl),
		.o_q     (ack_s)
	);

	always_ff @(posedge link.sclk or posedge i_reset) begin
		if (i_reset) begin
			ack_seen <= 1'b0;
			rd_buf   <= '0;
		end else if (ack_s != ack_seen) begin
			ack_seen <= ack_s;
			rd_buf   <= rd_hold;
		end
	end

	// ----------------------------------------------------------------
	// Output shifter on the falling edge
	// ----------------------------------------------------------------
	always_ff @(negedge link.sclk or posedge frame_rst) begin
		if (frame_rst) begin
			tx  <= '0;
			drv <= 1'b0; // RQ17
		end else if (rw && (cnt == CNT_DATA || cnt == CNT_WRAP)) begin
			tx  <= rd_buf; // RQ10 RQ14
			drv <= 1'b1; // RQ3
		end else begin
			tx  <= {tx[6:0], 1'b0}; // RQ3
		end
	end

	// Drivers never start on their own; both fall off with select high.
	assign link.dev_miso_o  = tx[7];
	assign link.dev_miso_oe = drv & ~link.cs_n & ~wire3; // RQ1 RQ15 RQ17
	assign link.dev_sdio_o  = tx[7];
	assign link.dev_sdio_oe = drv & ~link.cs_n & wire3; // RQ13 RQ14

	// ----------------------------------------------------------------
	// Host-clock side: write strobe and read fetch
	// ----------------------------------------------------------------
	spr_sync #(.W(2)) u_req_sync (
		.i_clk   (i_mclk),
		.i_reset (i_reset),
		.i_d     ({rq_tgl, wr_tgl}),
		.o_q     (req_s)
	);

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			req_seen   <= '0;
			o_wr_valid <= 1'b0;
			o_wr_addr  <= '0;
			o_wr_data  <= '0;
		end else begin
			req_seen   <= req_s;
			o_wr_valid <= req_s[0] ^ req_seen[0];
			if (req_s[0] ^ req_seen[0]) begin
				o_wr_addr <= wr_addr;
				o_wr_data <= wr_data;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_rd_addr <= '0;
			rd_pend   <= 1'b0;
			rd_hold   <= '0;
			ack_tgl   <= 1'b0;
		end else if (req_s[1] ^ req_seen[1]) begin
			o_rd_addr <= rq_addr;
			rd_pend   <= 1'b1;
		end else if (rd_pend) begin
			rd_hold <= i_rd_data;
			ack_tgl <= ~ack_tgl;
			rd_pend <= 1'b0;
		end
	end
endmodule

/* spr_host.sv */
// Purpose: Primary end: runs one framed register transfer per start.
// Assumes: Caller keeps i_wr_data valid until o_wr_take.
// Notes:   Serial clock is divided from i_mclk, under 4 MHz.
`timescale 1ns/1ns
module spr_host
	import spr_pkg::*;
#(
	parameter int LEN_W = 8
) (
	spr_if.host                  link,
	input  wire logic            i_mclk,
	input  wire logic            i_reset,
	input  wire logic            i_start,
	input  wire logic            i_rw,
	input  wire logic  [6:0]     i_addr,
	input  wire logic [LEN_W-1:0] i_len,
	input  wire logic            i_wire3,
	input  wire logic  [7:0]     i_wr_data,
	output logic                 o_wr_take,
	output logic                 o_rd_valid,
	output logic       [7:0]     o_rd_data,
	output logic                 o_busy
);
	typedef enum {H_IDLE, H_SETUP, H_XFER, H_HOLD, H_GAP} spr_host_e;

	spr_host_e         state;
	logic [TMR_W-1:0]  tmr;
	logic [LEN_W+3:0]  hcnt;
	logic [LEN_W+3:0]  total;
	logic              rw;
	logic              wire3;
	logic [7:0]        tx;
	logic [7:0]        rx;
	logic [1:0]        pin_s;
	logic              sin;
	logic [LEN_W+3:0]  next_hcnt;

	spr_sync #(.W(2)) u_pin_sync (
		.i_clk   (i_mclk),
		.i_reset (i_reset),
		.i_d     ({link.sdio, link.miso}),
		.o_q     (pin_s)
	);

	assign sin          = wire3 ? pin_s[1] : pin_s[0];
	assign next_hcnt    = hcnt + 1'b1;
	assign link.host_sdio_o = tx[7];
	assign o_busy       = (state != H_IDLE);

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			state             <= H_IDLE;
			tmr               <= '0;
			hcnt              <= '0;
			total             <= '0;
			rw                <= 1'b0;
			wire3             <= 1'b0;
			tx                <= '0;
			rx                <= '0;
			link.sclk         <= 1'b0;
			link.cs_n         <= 1'b1;
			link.host_sdio_oe <= 1'b0;
			o_wr_take         <= 1'b0;
			o_rd_valid        <= 1'b0;
			o_rd_data         <= '0;
		end else begin
			o_wr_take  <= 1'b0;
			o_rd_valid <= 1'b0;
			if (tmr != '0)
				tmr <= tmr - 1'b1;
			case (state)
			H_IDLE: begin
				if (i_start) begin
					rw                <= i_rw;
					wire3             <= i_wire3;
					tx                <= {i_rw, i_addr}; // RQ6 RQ7
					total             <= {(i_len == '0) ? LEN_W'(1) : i_len, 3'h0} + (LEN_W+4)'(16); // RQ5
					hcnt              <= '0;
					link.cs_n         <= 1'b0; // RQ4
					link.host_sdio_oe <= 1'b1;
					tmr               <= TMR_W'(CS_SETUP_CYC - 1);
					state             <= H_SETUP;
				end
			end
			H_SETUP: begin
				if (tmr == '0) begin
					tmr   <= TMR_W'(SCLK_HALF_CYC - 1); // RQ16
					state <= H_XFER;
				end
			end
			H_XFER: begin
				if (tmr == '0 && !link.sclk) begin
					tmr       <= TMR_W'(SCLK_HALF_CYC - 1);
					link.sclk <= 1'b1; // RQ2
					rx        <= {rx[6:0], sin}; // RQ3
					hcnt      <= next_hcnt;
					if (rw && next_hcnt >= (LEN_W+4)'(24) && next_hcnt[2:0] == 3'h0) begin
						o_rd_valid <= 1'b1;
						o_rd_data  <= {rx[6:0], sin};
					end
				end else if (tmr == '0) begin
					tmr       <= TMR_W'(SCLK_HALF_CYC - 1);
					link.sclk <= 1'b0; // RQ3
					if (hcnt == total) begin
						link.host_sdio_oe <= 1'b0;
						tmr               <= TMR_W'(CS_HOLD_CYC - 1);
						state             <= H_HOLD;
					end else if (hcnt[2:0] == 3'h0) begin
						if (hcnt == (LEN_W+4)'(8)) begin
							tx <= DUMMY_BYTE; // RQ9
						end else begin
							tx        <= i_wr_data; // RQ9
							o_wr_take <= !rw;
						end
						if (rw && (wire3 || hcnt >= (LEN_W+4)'(16)))
							link.host_sdio_oe <= (hcnt < (LEN_W+4)'(16)); // RQ14
					end else begin
						tx <= {tx[6:0], 1'b0};
					end
				end
			end
			H_HOLD: begin
				if (tmr == '0) begin
					link.cs_n <= 1'b1; // RQ4 RQ12
					tmr       <= TMR_W'(CS_IDLE_CYC - 1);
					state     <= H_GAP;
				end
			end
			H_GAP: begin
				if (tmr == '0)
					state <= H_IDLE;
			end
			default: begin
				state <= H_IDLE;
			end
			endcase
		end
	end
endmodule

/* spr_port_sva.sv */
// Purpose: Link checks between the host and device ends.
// Assumes: Frame counters clear while select is high.
// Notes:   Sclk-edge and i_mclk-sampled properties.
`timescale 1ns/1ns
module spr_port_sva (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio,
	input wire logic host_sdio_o,
	input wire logic host_sdio_oe,
	input wire logic dev_sdio_o,
	input wire logic dev_sdio_oe,
	input wire logic dev_miso_o,
	input wire logic dev_miso_oe
);
	logic [7:0] cnt;
	logic       rw;
	logic [7:0] flen;

	// ----------------------------------------------------------------
	// Frame tracking
	// ----------------------------------------------------------------
	always_ff @(posedge sclk or posedge cs_n)
		if (cs_n) cnt <= 8'h00;
		else cnt <= cnt + 8'h01;
	always_ff @(posedge sclk or posedge cs_n)
		if (cs_n) rw <= 1'b0;
		else if (cnt == 8'h00) rw <= sdio;
	always_ff @(posedge i_mclk or posedge i_reset)
		if (i_reset) flen <= 8'h00;
		else if (!cs_n) flen <= cnt;

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence s_frame_end;
		$rose(cs_n);
	endsequence
	property p_frame_len;
		@(posedge i_mclk) disable iff (i_reset) s_frame_end |-> (flen >= 8'h18) && (flen[2:0] == 3'h0);
	endproperty
	property p_idle_quiet;
		@(posedge i_mclk) disable iff (i_reset) cs_n |-> !dev_miso_oe && !dev_sdio_oe;
	endproperty
	property p_sclk_idle;
		@(posedge i_mclk) disable iff (i_reset) cs_n |-> !sclk;
	endproperty
	property p_no_clash;
		@(posedge i_mclk) disable iff (i_reset) dev_sdio_oe |-> !dev_miso_oe && !host_sdio_oe;
	endproperty
	property p_change_fall;
		@(posedge i_mclk) disable iff (i_reset) sclk && $past(sclk) |-> $stable({dev_miso_oe, dev_sdio_oe})
			&& (!host_sdio_oe || $stable(host_sdio_o)) && (!dev_miso_oe || $stable(dev_miso_o))
			&& (!dev_sdio_oe || $stable(dev_sdio_o));
	endproperty
	property p_rd_drive;
		@(posedge sclk) disable iff (i_reset) (cnt >= 8'h10) && rw |-> dev_miso_oe ^ dev_sdio_oe;
	endproperty
	property p_addr_quiet;
		@(posedge sclk) disable iff (i_reset) (cnt < 8'h10) |-> !dev_miso_oe && !dev_sdio_oe;
	endproperty
	property p_wr_quiet;
		@(posedge sclk) disable iff (i_reset) (cnt != 8'h00) && !rw |-> !dev_miso_oe && !dev_sdio_oe;
	endproperty

	a_frame_len:
		assert property (p_frame_len) else $error("frame not 24 clocks plus whole bytes");
	a_idle_quiet:
		assert property (p_idle_quiet) else $error("device drives while deselected");
	a_sclk_idle:
		assert property (p_sclk_idle) else $error("serial clock high while idle");
	a_no_clash:
		assert property (p_no_clash) else $error("data pin driven by two parties");
	a_change_fall:
		assert property (p_change_fall) else $error("data changed while clock high");
	a_rd_drive:
		assert property (p_rd_drive) else $error("read data not driven on one pin");
	a_addr_quiet:
		assert property (p_addr_quiet) else $error("device drives before pulse 17");
	a_wr_quiet:
		assert property (p_wr_quiet) else $error("device drives during a write");
endmodule

/* test_spi_register_port_secondary.sv */
// Purpose: Self-checking bench joining host and device ends.
// Assumes: Register map is modelled here on the device side.
// Notes:   Seeded random frames plus wrap and mode corners.
`timescale 1ns/1ns
module test_spi_register_port_secondary
	import spr_pkg::*;
();
	logic        i_mclk;
	logic        i_reset    = 1'b0;
	logic        i_start    = 1'b0;
	logic        i_rw       = 1'b0;
	logic        i_wire3    = 1'b0;
	logic [6:0]  i_addr     = 7'h00;
	logic [7:0]  i_len      = 8'h01;
	logic [7:0]  i_wr_data  = 8'h00;
	logic        o_wr_take;
	logic        o_rd_valid;
	logic        o_busy;
	logic        o_wr_valid;
	logic [6:0]  o_wr_addr;
	logic [6:0]  o_rd_addr;
	logic [7:0]  o_rd_data;
	logic [7:0]  o_wr_data;
	logic [7:0]  i_rd_data;
	logic [7:0]  mem [128];
	logic [7:0]  exp_mem [128];
	logic [7:0]  wbuf [16];
	logic [14:0] wq [$];
	logic [7:0]  rq [$];
	int          widx;
	int          num_errors;
	int          cmp_count;

	spr_if i_spr_if ();
	spr_host #(.LEN_W(8)) i_spr_host (.link(i_spr_if), .i_mclk(i_mclk), .i_reset(i_reset), .i_start(i_start),
		.i_rw(i_rw), .i_addr(i_addr), .i_len(i_len), .i_wire3(i_wire3), .i_wr_data(i_wr_data),
		.o_wr_take(o_wr_take), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_busy(o_busy));
	spr_device i_spr_device (.link(i_spr_if), .i_mclk(i_mclk), .i_reset(i_reset), .o_wr_valid(o_wr_valid),
		.o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data));
	spr_port_sva i_spr_port_sva (.i_mclk(i_mclk), .i_reset(i_reset), .sclk(i_spr_if.sclk),
		.cs_n(i_spr_if.cs_n), .sdio(i_spr_if.sdio), .host_sdio_o(i_spr_if.host_sdio_o),
		.host_sdio_oe(i_spr_if.host_sdio_oe), .dev_sdio_o(i_spr_if.dev_sdio_o),
		.dev_sdio_oe(i_spr_if.dev_sdio_oe), .dev_miso_o(i_spr_if.dev_miso_o),
		.dev_miso_oe(i_spr_if.dev_miso_oe));

	// ----------------------------------------------------------------
	// Register map and capture
	// ----------------------------------------------------------------
	assign i_rd_data = mem[o_rd_addr];
	always @(posedge i_mclk) begin
		if (o_wr_valid === 1'b1) begin
			mem[o_wr_addr] <= o_wr_data;
			wq.push_back({o_wr_addr, o_wr_data});
		end
		if (o_rd_valid === 1'b1) rq.push_back(o_rd_data);
		if (i_start === 1'b1)
			widx <= 0;
		else if (o_wr_take === 1'b1)
			widx <= widx + 1;
	end
	always @(negedge i_mclk) i_wr_data <= wbuf[widx];

	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [6:0] nth(input logic [6:0] a, input int i);
		return a + i[6:0];
	endfunction

	task automatic check(input string what, input logic [14:0] seen, input logic [14:0] want);
		cmp_count++;
		if (seen !== want) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic xfer(input logic rw, input logic [6:0] a, input int n, input logic w3);
		int k;
		@(negedge i_mclk);
		wq.delete();
		rq.delete();
		for (int i = 0; i < 16; i++) wbuf[i] = 8'($urandom());
		i_rw = rw;
		i_addr = a;
		i_len = 8'(n);
		i_wire3 = w3;
		i_start = 1'b1;
		if (!rw && a == CFG_REG_ADDR) wbuf[0] = 8'(1 << CFG_WIRE3_BIT);
		@(negedge i_mclk);
		i_start = 1'b0;
		for (k = 0; k < 3000 && o_busy !== 1'b0; k++) @(negedge i_mclk);
		check("frame_done", 15'(k < 3000), 15'h0001);
		if (rw) begin
			check("rd_count", 15'(rq.size()), 15'(n));
			for (int i = 0; i < n; i++) check("rd_data", 15'(rq[i]), 15'(exp_mem[nth(a, i)]));
		end else begin
			check("wr_count", 15'(wq.size()), 15'(n));
			for (int i = 0; i < n; i++) begin
				check("wr_word", wq[i], {nth(a, i), wbuf[i]});
				exp_mem[nth(a, i)] = wbuf[i];
			end
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		// Real rising edge: sclk-side flops see no clock edge in reset
		#1 i_reset = 1'b1;
		void'($urandom(20));
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'($urandom());
			exp_mem[i] = mem[i];
		end
		repeat (12) @(posedge i_mclk);
		@(negedge i_mclk);
		i_reset = 1'b0;
		xfer(1'b0, 7'h7E, 3, 1'b0);
		xfer(1'b1, 7'h7E, 3, 1'b0);
		for (int t = 0; t < 16; t++) begin
			if (t == 8) xfer(1'b0, CFG_REG_ADDR, 1, 1'b0);
			xfer(1'($urandom_range(0, 1)), 7'h20 + 7'($urandom_range(0, 80)), $urandom_range(1, 4), t >= 8);
		end
		xfer(1'b1, CFG_REG_ADDR, 1, 1'b1);
		i_reset = 1'b1;
		repeat (3) @(negedge i_mclk);
		i_reset = 1'b0;
		xfer(1'b1, 7'h7E, 4, 1'b0);
		complete_run();
	end

	initial begin
		#600000;
		num_errors++;
		complete_run();
	end
endmodule
